// ==== rtl/dflush_pkg.sv ====
// Package with constants for the indexed data-cache flush block
package dflush_pkg;
  // ----------------------------------------------------------------
  // Instruction fields (immediate format)
  // ----------------------------------------------------------------
  localparam int INSN_W        = 32;
  localparam int REG_IDX_W     = 5;
  localparam int BASE_REG_LSB  = 27;
  localparam int IMM_W         = 16;
  localparam int IMM_LSB       = 6;
  localparam int OPCODE_W      = 6;
  localparam int OPCODE_LSB    = 0;
  localparam logic [5:0] OP_FLUSH_INDEXED = 6'h3b;
  // ----------------------------------------------------------------
  // Address and cache geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 32;
  localparam int DATA_W        = 32;
  localparam int LINE_IDX_W    = 6;
  localparam int WORD_SEL_W    = 3;
  localparam int BYTE_SEL_W    = 2;
  localparam int TAG_W         = ADDR_W - LINE_IDX_W - WORD_SEL_W - BYTE_SEL_W;
  localparam int LINE_IDX_LSB  = WORD_SEL_W + BYTE_SEL_W;
  localparam int TAG_LSB       = LINE_IDX_LSB + LINE_IDX_W;
  // Flush sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_WRITEBACK,
    ST_DONE
  } flush_state_t;
endpackage

// ==== rtl/dflush_addr_gen.sv ====
// Effective address and line index generation for the flush instruction
`timescale 1ns/1ps
module dflush_addr_gen #(
  parameter int ADDR_W   = dflush_pkg::ADDR_W,
  parameter int IMM_W    = dflush_pkg::IMM_W,
  parameter int IDX_W    = dflush_pkg::LINE_IDX_W,
  parameter int IDX_LSB  = dflush_pkg::LINE_IDX_LSB
) (
  input  wire logic [ADDR_W-1:0] base_register,     // Base register value
  input  wire logic [IMM_W-1:0]  signed_offset_imm, // Signed immediate offset
  output logic      [ADDR_W-1:0] eff_addr,          // Effective address
  output logic      [IDX_W-1:0]  line_idx           // Line index field
);
  // Sign extend the offset and add it to the base
  always_comb begin
    eff_addr = base_register + {{(ADDR_W-IMM_W){signed_offset_imm[IMM_W-1]}},
                                signed_offset_imm};
    line_idx = eff_addr[IDX_LSB +: IDX_W];
  end
endmodule

// ==== rtl/dflush_line_buf.sv ====
// Word-count register for streaming one line out on write-back
`timescale 1ns/1ps
module dflush_line_buf #(
  parameter int CNT_W = dflush_pkg::WORD_SEL_W
) (
  input  wire logic             clk_sys, // System clock
  input  wire logic             rst_n,   // Async reset, active low
  input  wire logic             ce,      // Clock enable
  input  wire logic             clr,     // Restart at word zero
  input  wire logic             adv,     // Advance one word
  output logic      [CNT_W-1:0] cnt_ff,  // Current word number
  output logic                  last     // Current word is the last
);
  // Word counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (clr) begin
        cnt_ff <= '0;
      end else if (adv) begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end
  assign last = (cnt_ff == {CNT_W{1'b1}});
endmodule

// ==== rtl/data_cache_index_flush.sv ====
// Indexed data-cache flush: direct-mapped cache with line write-back
// How it works
// - Effective address is base register plus sign-extended 16-bit offset.
// - Line chosen by the line-index field only; tag field ignored.
// - Stored tag never compared against effective address.
// - Line flushed even when the addressed location is not cached.
// - A dirty selected line is written back to memory.
// - A processor store to a line's word marks it dirty, except while busy_ff is set, when the store is dropped.
// - Valid bit of the selected line is cleared after write-back.
// - Without a data cache the flush is a no-operation.
// - Decoded as immediate format: base register index and 16-bit offset.
// - Cache is direct mapped; one line per index.
`timescale 1ns/1ps
module data_cache_index_flush #(
  parameter bit HAS_DCACHE = 1'b1,
  parameter int LINE_IDX_W = dflush_pkg::LINE_IDX_W,
  parameter int WORD_SEL_W = dflush_pkg::WORD_SEL_W
) (
  input  wire logic                          clk_sys,       // System clock
  input  wire logic                          rst_n,         // Async reset, active low
  input  wire logic                          ce,            // Clock enable
  // Pipeline side
  input  wire logic                          insn_valid,    // Instruction presented
  input  wire logic [dflush_pkg::INSN_W-1:0] insn_word,     // Instruction word
  input  wire logic [dflush_pkg::ADDR_W-1:0] base_register, // Value of base register
  output logic [dflush_pkg::REG_IDX_W-1:0]   base_idx_ff,   // Base register index
  output logic                               busy_ff,       // Stall the pipeline
  output logic                               retire_ff,     // Flush retired pulse
  // Processor store port into the cache
  input  wire logic                          st_valid,      // Store hits cache line
  input  wire logic [dflush_pkg::ADDR_W-1:0] st_addr,       // Store address
  input  wire logic [dflush_pkg::DATA_W-1:0] st_data,       // Store data
  // Memory write-back bus
  output logic                               mem_wr_ff,     // Write request
  output logic [dflush_pkg::ADDR_W-1:0]      mem_addr_ff,   // Write address
  output logic [dflush_pkg::DATA_W-1:0]      mem_wdata_ff,  // Write data
  input  wire logic                          mem_ack        // Write accepted
);
  // ----------------------------------------------------------------
  // Decode and address generation
  // ----------------------------------------------------------------
  localparam int LINES = 1 << LINE_IDX_W;
  localparam int WORDS = 1 << WORD_SEL_W;
  localparam int TAG_W = dflush_pkg::TAG_W;

  logic                          is_flush;
  logic [dflush_pkg::IMM_W-1:0]  signed_offset_imm;
  logic [dflush_pkg::ADDR_W-1:0] eff_addr;
  logic [LINE_IDX_W-1:0]         line_idx;

  // Immediate-format decode of opcode and offset
  assign is_flush = insn_valid && (insn_word[dflush_pkg::OPCODE_LSB +: dflush_pkg::OPCODE_W]
                    == dflush_pkg::OP_FLUSH_INDEXED);
  assign signed_offset_imm = insn_word[dflush_pkg::IMM_LSB +: dflush_pkg::IMM_W];

  dflush_addr_gen #(
    .ADDR_W  (dflush_pkg::ADDR_W),
    .IMM_W   (dflush_pkg::IMM_W),
    .IDX_W   (LINE_IDX_W),
    .IDX_LSB (dflush_pkg::LINE_IDX_LSB)
  ) u_addr (
    .base_register     (base_register),
    .signed_offset_imm (signed_offset_imm),
    .eff_addr          (eff_addr),
    .line_idx          (line_idx)
  );

  // ----------------------------------------------------------------
  // Cache storage: one entry per index, direct mapped
  // ----------------------------------------------------------------
  logic                  valid_ff [LINES];
  logic                  dirty_ff [LINES];
  logic [TAG_W-1:0]      tag_ff   [LINES];
  logic [dflush_pkg::DATA_W-1:0] data_ff [LINES][WORDS];

  dflush_pkg::flush_state_t state_ff;
  logic [LINE_IDX_W-1:0]    sel_idx_ff;
  logic [WORD_SEL_W-1:0]    word_cnt;
  logic                     word_last;
  logic                     cnt_clr;
  logic                     cnt_adv;
  logic                     inval;
  logic [LINE_IDX_W-1:0]    st_idx;
  logic [WORD_SEL_W-1:0]    st_word;

  assign st_idx  = st_addr[dflush_pkg::LINE_IDX_LSB +: LINE_IDX_W];
  assign st_word = st_addr[dflush_pkg::BYTE_SEL_W +: WORD_SEL_W];
  assign inval   = (state_ff == dflush_pkg::ST_DONE);

  dflush_line_buf #(
    .CNT_W (WORD_SEL_W)
  ) u_cnt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .clr     (cnt_clr),
    .adv     (cnt_adv),
    .cnt_ff  (word_cnt),
    .last    (word_last)
  );

  // ----------------------------------------------------------------
  // Flush sequencer
  // ----------------------------------------------------------------
  assign cnt_clr = (state_ff == dflush_pkg::ST_LOOKUP);
  assign cnt_adv = (state_ff == dflush_pkg::ST_WRITEBACK) && mem_wr_ff && mem_ack;

  // State, stall and retire control
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= dflush_pkg::ST_IDLE;
      sel_idx_ff  <= '0;
      base_idx_ff <= '0;
      busy_ff     <= 1'b0;
      retire_ff   <= 1'b0;
    end else if (ce) begin
      retire_ff <= 1'b0;
      case (state_ff)
        dflush_pkg::ST_IDLE: begin
          if (is_flush) begin
            base_idx_ff <= insn_word[dflush_pkg::BASE_REG_LSB +: dflush_pkg::REG_IDX_W];
            if (HAS_DCACHE) begin
              sel_idx_ff <= line_idx;
              busy_ff    <= 1'b1;
              state_ff   <= dflush_pkg::ST_LOOKUP;
            end else begin
              retire_ff  <= 1'b1;
            end
          end
        end
        dflush_pkg::ST_LOOKUP: begin
          if (valid_ff[sel_idx_ff] && dirty_ff[sel_idx_ff]) begin
            state_ff <= dflush_pkg::ST_WRITEBACK;
          end else begin
            state_ff <= dflush_pkg::ST_DONE;
          end
        end
        dflush_pkg::ST_WRITEBACK: begin
          if (cnt_adv && word_last) begin
            state_ff <= dflush_pkg::ST_DONE;
          end
        end
        dflush_pkg::ST_DONE: begin
          busy_ff   <= 1'b0;
          retire_ff <= 1'b1;
          state_ff  <= dflush_pkg::ST_IDLE;
        end
        default: begin
          state_ff <= dflush_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Memory write request, one word at a time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_ff    <= 1'b0;
      mem_addr_ff  <= '0;
      mem_wdata_ff <= '0;
    end else if (ce) begin
      if (state_ff == dflush_pkg::ST_WRITEBACK && !(cnt_adv && word_last)) begin
        mem_wr_ff    <= 1'b1;
        mem_addr_ff  <= {tag_ff[sel_idx_ff], sel_idx_ff,
                         (cnt_adv ? word_cnt + WORD_SEL_W'(1) : word_cnt),
                         {dflush_pkg::BYTE_SEL_W{1'b0}}};
        mem_wdata_ff <= data_ff[sel_idx_ff][cnt_adv ? word_cnt + WORD_SEL_W'(1) : word_cnt];
      end else begin
        mem_wr_ff    <= 1'b0;
      end
    end
  end

  // Valid, dirty and tag per line; stores fill and dirty, flush clears
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LINES; i++) begin
        valid_ff[i] <= 1'b0;
        dirty_ff[i] <= 1'b0;
        tag_ff[i]   <= '0;
      end
    end else if (ce) begin
      if (st_valid && !busy_ff) begin
        valid_ff[st_idx] <= 1'b1;
        dirty_ff[st_idx] <= 1'b1;
        tag_ff[st_idx]   <= st_addr[dflush_pkg::TAG_LSB +: TAG_W];
      end
      if (inval) begin
        valid_ff[sel_idx_ff] <= 1'b0;
        dirty_ff[sel_idx_ff] <= 1'b0;
      end
    end
  end

  // Line data words
  always_ff @(posedge clk_sys) begin
    if (ce && st_valid && !busy_ff) begin
      data_ff[st_idx][st_word] <= st_data;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_nocache_nop;
    @(posedge clk_sys) disable iff (!rst_n)
    (!HAS_DCACHE) |-> !busy_ff && !mem_wr_ff;
  endproperty
  a_nocache_nop: assert property (p_nocache_nop) else $error("flush not a nop");

  property p_clean_no_write;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_ff == dflush_pkg::ST_LOOKUP && !(valid_ff[sel_idx_ff] && dirty_ff[sel_idx_ff]))
      |=> !mem_wr_ff [*2];
  endproperty
  a_clean_no_write: assert property (p_clean_no_write) else $error("clean line wrote");

  property p_dirty_writes;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_ff == dflush_pkg::ST_LOOKUP && valid_ff[sel_idx_ff] && dirty_ff[sel_idx_ff])
      |=> ##1 mem_wr_ff;
  endproperty
  a_dirty_writes: assert property (p_dirty_writes) else $error("dirty not written");

  property p_inval_after;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_ff == dflush_pkg::ST_DONE) |=> !valid_ff[$past(sel_idx_ff)];
  endproperty
  a_inval_after: assert property (p_inval_after) else $error("line still valid");

  property p_busy_while_wb;
    @(posedge clk_sys) disable iff (!rst_n)
    mem_wr_ff |-> busy_ff && !retire_ff;
  endproperty
  a_busy_while_wb: assert property (p_busy_while_wb) else $error("retired early");

  property p_index_only;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_ff == dflush_pkg::ST_IDLE && is_flush && HAS_DCACHE)
      |=> sel_idx_ff == $past(line_idx) && state_ff == dflush_pkg::ST_LOOKUP;
  endproperty
  a_index_only: assert property (p_index_only) else $error("wrong line");

  property p_eff_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    is_flush |-> eff_addr == base_register
      + {{(dflush_pkg::ADDR_W-dflush_pkg::IMM_W){signed_offset_imm[dflush_pkg::IMM_W-1]}},
         signed_offset_imm};
  endproperty
  a_eff_addr: assert property (p_eff_addr) else $error("bad address");

  property p_store_dirty;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && st_valid && !busy_ff && !inval) |=> dirty_ff[$past(st_idx)];
  endproperty
  a_store_dirty: assert property (p_store_dirty) else $error("store not dirty");

  property p_retire_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && retire_ff && HAS_DCACHE) |=> !retire_ff;
  endproperty
  a_retire_pulse: assert property (p_retire_pulse) else $error("retire not a pulse");

  property p_hold_req;
    @(posedge clk_sys) disable iff (!rst_n)
    (mem_wr_ff && !mem_ack) |=> mem_wr_ff && $stable(mem_addr_ff) && $stable(mem_wdata_ff);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("request dropped before ack");

  property p_line_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    mem_wr_ff |-> mem_addr_ff[dflush_pkg::LINE_IDX_LSB +: LINE_IDX_W] == sel_idx_ff;
  endproperty
  a_line_addr: assert property (p_line_addr) else $error("write-back to other line");

  property p_first_word;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(mem_wr_ff) |-> mem_addr_ff[dflush_pkg::BYTE_SEL_W +: WORD_SEL_W] == '0;
  endproperty
  a_first_word: assert property (p_first_word) else $error("write-back not from word zero");

  property p_busy_retire;
    @(posedge clk_sys) disable iff (!rst_n)
    retire_ff |-> !busy_ff;
  endproperty
  a_busy_retire: assert property (p_busy_retire) else $error("still busy at retire");

  property p_hold_busy;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && busy_ff && state_ff != dflush_pkg::ST_DONE) |=> busy_ff && $stable(sel_idx_ff);
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("flush taken while busy");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_dirty_flush: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_ff == dflush_pkg::ST_WRITEBACK ##[1:40] retire_ff);
  c_clean_flush: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_ff == dflush_pkg::ST_LOOKUP ##1 state_ff == dflush_pkg::ST_DONE);
  c_stall: cover property (@(posedge clk_sys) disable iff (!rst_n)
    (mem_wr_ff && !mem_ack) [*3]);
  c_nocache_retire: cover property (@(posedge clk_sys) disable iff (!rst_n)
    !HAS_DCACHE && retire_ff);
  c_refused_offer: cover property (@(posedge clk_sys) disable iff (!rst_n)
    busy_ff && is_flush);
endmodule

// ==== verif/dflush_mem_model.sv ====
// Memory bus partner that accepts write-back words after a chosen delay
`timescale 1ns/1ps
module dflush_mem_model (
  input  wire logic       clk_sys,   // System clock
  input  wire logic       rst_n,     // Async reset, active low
  input  wire logic       mem_wr_ff, // Write request from the cache
  input  wire logic [1:0] slow,      // Extra wait cycles before accepting
  output logic            mem_ack    // Write accepted pulse
);
  logic [1:0] wait_ff;

  // Accept one word per request after the wait, then drop the pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'h0;
      wait_ff <= 2'h0;
    end else if (mem_wr_ff && !mem_ack) begin
      if (wait_ff >= slow) begin
        mem_ack <= 1'h1;
        wait_ff <= 2'h0;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end else begin
      mem_ack <= 1'h0;
    end
  end
endmodule

// ==== verif/data_cache_index_flush_bench.sv ====
// Self-checking bench for the indexed data-cache flush block
`timescale 1ns/1ps
module data_cache_index_flush_bench;
  logic        clk_sys = 1'h0;
  logic        rst_n = 1'h0;
  logic        ce = 1'h1;
  logic        insn_valid = 1'h0;
  logic [31:0] insn_word = 32'h0;
  logic [31:0] base_register = 32'h0;
  logic        st_valid = 1'h0;
  logic [31:0] st_addr = 32'h0;
  logic [31:0] st_data = 32'h0;
  logic [1:0]  slow = 2'h0;
  logic [4:0]  base_idx_ff;
  logic        busy_ff, retire_ff, mem_wr_ff, mem_ack, busy_nc, retire_nc, mem_wr_nc;
  logic [31:0] mem_addr_ff, mem_wdata_ff;
  logic [63:0] exp_q[$];
  logic [4:0]  ret_q[$];
  integer      seed = 11532;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #25 clk_sys = ~clk_sys;

  data_cache_index_flush #(.HAS_DCACHE(1'h1)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .insn_valid(insn_valid), .insn_word(insn_word), .base_register(base_register),
    .base_idx_ff(base_idx_ff), .busy_ff(busy_ff), .retire_ff(retire_ff), .st_valid(st_valid),
    .st_addr(st_addr), .st_data(st_data), .mem_wr_ff(mem_wr_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack));
  data_cache_index_flush #(.HAS_DCACHE(1'h0)) dut_nc (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .insn_valid(insn_valid), .insn_word(insn_word), .base_register(base_register),
    .base_idx_ff(), .busy_ff(busy_nc), .retire_ff(retire_nc), .st_valid(st_valid),
    .st_addr(st_addr), .st_data(st_data), .mem_wr_ff(mem_wr_nc), .mem_addr_ff(),
    .mem_wdata_ff(), .mem_ack(1'h0));
  dflush_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .mem_wr_ff(mem_wr_ff), .slow(slow),
    .mem_ack(mem_ack));

  // Compare and count, report a mismatch at once
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Store all eight words of one line, noting the expected write-back
  task automatic fill_line(input logic [20:0] tag, input logic [5:0] idx);
    for (int w = 0; w < 8; w++) begin
      @(posedge clk_sys) #2;
      st_valid = 1'h1;
      st_addr = {tag, idx, 3'(w), 2'h0};
      st_data = $random(seed);
      exp_q.push_back({st_addr, st_data});
    end
    @(posedge clk_sys) #2;
    st_valid = 1'h0;
  endtask

  // Issue one flush, offer a refused one while busy, count cycles to retire
  task automatic flush(input logic [4:0] ridx, input logic [31:0] base, input logic [15:0] imm,
                       input int exp_n);
    int n;
    @(posedge clk_sys) #2;
    insn_valid = 1'h1;
    insn_word = {ridx, 5'h00, imm, dflush_pkg::OP_FLUSH_INDEXED};
    base_register = base;
    ret_q.push_back(ridx);
    @(posedge clk_sys) #2;
    insn_valid = 1'h0;
    check(64'(retire_nc), 64'h1);
    n = 0;
    do begin
      @(posedge clk_sys) #2;
      n++;
      insn_valid = (n == 1) ? 1'h1 : 1'h0;
    end while (retire_ff !== 1'h1 && n < 400);
    if (retire_ff !== 1'h1) check(64'h0, 64'h1);
    if (exp_n > 0) check(64'(n), 64'(exp_n));
  endtask

  // Watch the write-back bus and the retire pulse against the notes
  always @(posedge clk_sys) begin
    if (rst_n && mem_wr_ff === 1'h1 && mem_ack === 1'h1) begin
      if (exp_q.size() == 0) check({mem_addr_ff, mem_wdata_ff}, 64'h0);
      else check({mem_addr_ff, mem_wdata_ff}, exp_q.pop_front());
    end
    if (rst_n && retire_ff === 1'h1) begin
      check(64'(exp_q.size()), 64'h0);
      check(64'(base_idx_ff), 64'(ret_q.pop_front()));
    end
    if (rst_n && (busy_nc !== 1'h0 || mem_wr_nc !== 1'h0)) check(64'h1, 64'h0);
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    logic [5:0]  idx;
    logic [20:0] tag;
    logic [15:0] imm;
    logic [31:0] base;
    logic [4:0]  ridx;
    repeat (6) @(posedge clk_sys);
    #2 rst_n = 1'h1;
    for (int k = 0; k < 4; k++) begin
      idx = 6'($random(seed));
      tag = 21'($random(seed));
      imm = (k == 0) ? 16'h8000 : 16'($random(seed));
      ridx = 5'($random(seed));
      slow = 2'(k);
      fill_line(tag, idx);
      // Same line index, other tag: the dirty line must still be written back
      base = {~tag, idx, 5'h00} - {{16{imm[15]}}, imm};
      // Dirty: the partner takes each of the eight words in slow plus two cycles
      flush(ridx, base, imm, 3 + 8 * (k + 2));
      flush(ridx, base + 32'h1c, imm, 2);
    end
    // Clock enable low: a flush offered then is not taken
    @(posedge clk_sys) #2;
    ce = 1'h0;
    insn_valid = 1'h1;
    insn_word = {5'h03, 5'h00, 16'h0040, dflush_pkg::OP_FLUSH_INDEXED};
    @(posedge clk_sys) #2;
    ce = 1'h1;
    insn_valid = 1'h0;
    check(64'(busy_ff), 64'h0);
    check(64'(retire_nc), 64'h0);
    // Wrong opcode is not a flush
    @(posedge clk_sys) #2;
    insn_valid = 1'h1;
    insn_word = {5'h03, 5'h00, 16'h0040, 6'h3a};
    @(posedge clk_sys) #2;
    insn_valid = 1'h0;
    @(posedge clk_sys) #1;
    check(64'(busy_ff), 64'h0);
    check(64'(retire_nc), 64'h0);
    repeat (4) @(posedge clk_sys);
    check(64'(exp_q.size()), 64'h0);
    check(64'(ret_q.size()), 64'h0);
    complete_run();
  end
endmodule
